// file: hw/token_bus_defines.svh
`ifndef TOKEN_BUS_DEFINES_SVH
`define TOKEN_BUS_DEFINES_SVH
// Notes on behaviour
// - Only the token holder transmits on bus; polled nodes also answer with K_ACK
// - Token passes upward by node address
// - Idle holder forwards token at once
// - Highest node returns token to lowest
// - Lowest address node is sole poller
// - Next higher node takes over failed poller
// - Startup node launches link with its settings
// - Auto allocation: word area; manual: common
// - Round runs from poller back to poller
// - Poller polls nodes after every round
// - Poller broadcasts membership after polling
// - Poller reissues token after control phase
// - Poller sends network parameters; others adopt
// - Host refreshes link words cyclically
// - Unit number 0 to F, unique per host
// - At most sixteen units, four network units
// - Address outside 01..62 lights error lamp
// - Node addresses unique on one network
// - Network address 1..127, zero means local
// - Never poll above maximum node address
// - Polled node count limits polling phase
// - Maximum frames caps events per round

// Clock and timing
`define CLK_NS            8
`define POLL_WAIT_NS      64
`define POLL_WAIT_CYC     ((`POLL_WAIT_NS + `CLK_NS - 1) / `CLK_NS)
`define LOSS_TIMEOUT_NS   40000
`define LOSS_TIMEOUT_CYC  (`LOSS_TIMEOUT_NS / `CLK_NS)
`define REFRESH_NS        10000
`define REFRESH_CYC       (`REFRESH_NS / `CLK_NS)

// Address ranges
`define ADDR_BOT          1
`define ADDR_TOP          62
`define ADDR_MIN          6'h01
`define ADDR_MAX          6'h3E
`define ADDR_NONE         6'h3F
`define NET_LOCAL         8'h00
`define NET_MAX           8'h7F

// Network parameter ranges and defaults
`define CYCLE_AUTO        8'h00
`define CYCLE_MIN         8'h05
`define POLLCNT_MIN       6'h01
`define POLLCNT_DEF       6'h04
`define FRAMES_MIN        8'h05
`define FRAMES_DEF        8'h0A
`define MAXADDR_MIN       6'h02

// Broadcast frame layout: dst field selects chunk or parameter
`define CHUNK_W           16
`define CHUNK_LAST        2'h3
`define PSEL_CYCLE        2'h0
`define PSEL_POLLCNT      2'h1
`define PSEL_FRAMES       2'h2
`define PSEL_MAXADDR      2'h3
`endif

// file: hw/token_bus_if.sv
`timescale 1ns/1ns
interface token_bus_if;
  import token_bus_pkg::*;
  frame_t      from_node;
  frame_t      from_peer;
  logic        host_wr_vld;
  logic [15:0] host_wr_dat;
  logic        rd_vld;
  logic [15:0] rd_dat;
  logic [5:0]  rd_src;

  modport node_end (output from_node, rd_vld, rd_dat, rd_src, input from_peer, host_wr_vld, host_wr_dat);
  modport peer_end (input from_node, rd_vld, rd_dat, rd_src, output from_peer, host_wr_vld, host_wr_dat);
endinterface : token_bus_if

// file: hw/token_bus_pkg.sv
`include "token_bus_defines.svh"
package token_bus_pkg;

  typedef enum logic [2:0] {K_TOKEN, K_POLL, K_ACK, K_MEMBER, K_PARAM, K_DATA, K_EVENT, K_LINKCFG} kind_t;

  typedef struct packed {
    logic        vld;
    kind_t       kind;
    logic [5:0]  dst;
    logic [5:0]  src;
    logic [15:0] dat;
  } frame_t;

  typedef enum logic [2:0] {ST_IDLE, ST_TURN, ST_POLL, ST_WAIT, ST_MEMBER, ST_PARAM} node_st_t;

  typedef struct packed {
    node_st_t    st;
    logic [5:0]  addr_m, addr_s;
    logic [3:0]  unit_m, unit_s;
    logic [7:0]  net_m, net_s;
    logic        lamp, poller, startup, link_on, cfg_sent, sent_dat, sent_evt, have_word;
    logic [7:0]  link_words;
    logic [63:0] mem;
    logic [7:0]  p_cycle, p_frames, evt_cnt;
    logic [5:0]  p_pollcnt, p_maxaddr, cursor, polled;
    logic [1:0]  chunk;
    logic [3:0]  wait_cnt;
    logic [15:0] quiet, link_word, rd_dat;
    frame_t      tx;
    logic        rd_vld, evt_ack, round_done, param_err, net_local, net_err;
    logic [5:0]  rd_src;
  } node_state_t;

  typedef struct packed {
    logic        hold_on, sent, got_vld, wr_vld, link_on;
    logic [5:0]  hold_addr, got_src, p_pollcnt, p_maxaddr;
    logic [7:0]  p_cycle, p_frames, link_words;
    logic [63:0] mem;
    logic [15:0] got_dat, refresh, wr_dat, host_rd;
    frame_t      tx;
  } peer_state_t;

  // Next present address above me within limit, else lowest present
  function automatic logic [5:0] next_up(input logic [63:0] ring, input logic [5:0] me, input logic [5:0] lim);
    logic [5:0] lo;
    logic [5:0] up;
    logic       found;
    lo    = me;
    up    = me;
    found = 1'b0;
    for (int i = `ADDR_TOP; i >= `ADDR_BOT; i--)
    begin
      if (ring[i] && 6'(i) <= lim)
      begin
        lo = 6'(i);
        if (6'(i) > me)
        begin
          up    = 6'(i);
          found = 1'b1;
        end
      end
    end
    return found ? up : lo;
  endfunction : next_up

endpackage : token_bus_pkg

// file: hw/token_node.sv
`timescale 1ns/1ns
`include "token_bus_defines.svh"
module token_node #(
  parameter int unsigned LOSS_CYC = `LOSS_TIMEOUT_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  token_bus_if.node_end    bus,
  input  wire logic [5:0]  i_node_addr,
  input  wire logic [3:0]  i_unit_num,
  input  wire logic [7:0]  i_net_addr,
  input  wire logic        i_start_link,
  input  wire logic        i_alloc_auto,
  input  wire logic [7:0]  i_pwa_words,
  input  wire logic [7:0]  i_clp_words,
  input  wire logic [7:0]  i_cfg_cycle,
  input  wire logic [5:0]  i_cfg_pollcnt,
  input  wire logic [7:0]  i_cfg_frames,
  input  wire logic [5:0]  i_cfg_maxaddr,
  input  wire logic        i_evt_req,
  input  wire logic [15:0] i_evt_dat,
  output logic             o_evt_ack,
  output logic             o_comm_error_lamp,
  output logic             o_poller,
  output logic             o_startup,
  output logic             o_link_on,
  output logic [7:0]       o_link_words,
  output logic [62:0]      o_members,
  output logic [7:0]       o_net_cycle,
  output logic [5:0]       o_net_pollcnt,
  output logic [7:0]       o_net_frames,
  output logic [5:0]       o_net_maxaddr,
  output logic             o_round_done,
  output logic             o_param_err,
  output logic [3:0]       o_unit_num,
  output logic             o_net_local,
  output logic             o_net_err
);
  import token_bus_pkg::*;

  node_state_t s;
  node_state_t next_s;

  always_comb
  begin
    logic [5:0]  me;
    logic [5:0]  nxt;
    logic [5:0]  low;
    logic [5:0]  cur;
    logic [63:0] ring2;
    logic [7:0]  c_cycle;
    logic [7:0]  c_frames;
    logic [5:0]  c_poll;
    logic [5:0]  c_max;
    logic        cfg_bad;
    frame_t      rx;
    me      = s.addr_s;
    rx      = bus.from_peer;
    nxt     = next_up(s.mem, s.addr_s, s.p_maxaddr);
    low     = next_up(s.mem, `ADDR_NONE, `ADDR_MAX);
    cur     = (s.cursor >= s.p_maxaddr) ? `ADDR_MIN : s.cursor + 6'h01;
    ring2   = s.mem;
    cfg_bad = (i_cfg_cycle != `CYCLE_AUTO && i_cfg_cycle < `CYCLE_MIN) || i_cfg_pollcnt < `POLLCNT_MIN
              || i_cfg_pollcnt > `ADDR_MAX || i_cfg_frames < `FRAMES_MIN
              || i_cfg_maxaddr < `MAXADDR_MIN || i_cfg_maxaddr > `ADDR_MAX;
    c_cycle  = cfg_bad ? `CYCLE_AUTO : i_cfg_cycle;
    c_poll   = cfg_bad ? `POLLCNT_DEF : i_cfg_pollcnt;
    c_frames = cfg_bad ? `FRAMES_DEF : i_cfg_frames;
    c_max    = cfg_bad ? `ADDR_MAX : i_cfg_maxaddr;
    next_s   = s;
    next_s.tx         = '0;
    next_s.rd_vld     = 1'b0;
    next_s.evt_ack    = 1'b0;
    next_s.round_done = 1'b0;
    next_s.param_err  = cfg_bad;

    // Switch synchronisers
    next_s.addr_m = i_node_addr;
    next_s.addr_s = s.addr_m;
    next_s.unit_m = i_unit_num;
    next_s.unit_s = s.unit_m;
    next_s.net_m  = i_net_addr;
    next_s.net_s  = s.net_m;

    // Address range checks
    next_s.lamp      = (me < `ADDR_MIN) || (me > `ADDR_MAX);
    next_s.net_local = (s.net_s == `NET_LOCAL);
    next_s.net_err   = (s.net_s > `NET_MAX);

    // Silence watchdog, cleared by any traffic or own activity
    if (rx.vld || s.st != ST_IDLE)
      next_s.quiet = 16'h0000;
    else if (s.quiet != 16'(LOSS_CYC))
      next_s.quiet = s.quiet + 16'h0001;

    // Host refresh of the local link word
    if (bus.host_wr_vld)
    begin
      next_s.link_word = bus.host_wr_dat;
      next_s.have_word = 1'b1;
    end

    // Data link launch by this node, once per reset
    if (i_start_link && !s.lamp && !s.startup)
    begin
      next_s.startup    = 1'b1;
      next_s.link_on    = 1'b1;
      next_s.cfg_sent   = 1'b0;
      next_s.link_words = i_alloc_auto ? i_pwa_words : i_clp_words;
    end

    // Frames from the other nodes
    if (rx.vld && !s.lamp)
    begin
      case (rx.kind)
        K_MEMBER:
          if (!s.poller)
            next_s.mem[{rx.dst[1:0], 4'h0} +: `CHUNK_W] = rx.dat;
        K_PARAM:
          if (!s.poller)
          begin
            case (rx.dst[1:0])
              `PSEL_CYCLE:
              begin
                next_s.p_cycle = rx.dat[7:0];
                next_s.evt_cnt = 8'h00;
              end
              `PSEL_POLLCNT: next_s.p_pollcnt = rx.dat[5:0];
              `PSEL_FRAMES:  next_s.p_frames  = rx.dat[7:0];
              default:       next_s.p_maxaddr = rx.dat[5:0];
            endcase
          end
        K_LINKCFG:
        begin
          next_s.link_words = rx.dat[7:0];
          next_s.link_on    = 1'b1;
        end
        K_EVENT:
          next_s.evt_cnt = s.evt_cnt + 8'h01;
        K_DATA:
        begin
          next_s.rd_vld = 1'b1;
          next_s.rd_dat = rx.dat;
          next_s.rd_src = rx.src;
        end
        K_POLL:
          if (rx.dst == me && s.st == ST_IDLE)
            next_s.tx = {1'b1, K_ACK, me, me, 16'h0000};
        K_TOKEN:
          if (rx.dst == me && s.st == ST_IDLE)
          begin
            if (s.poller)
            begin
              next_s.st         = ST_POLL;
              next_s.round_done = 1'b1;
              next_s.polled     = 6'h00;
            end
            else
              next_s.st = ST_TURN;
          end
        default: ;
      endcase
    end

    // Ring sequencer
    case (s.st)
      ST_IDLE:
        if (s.quiet == 16'(LOSS_CYC) && !s.lamp)
        begin
          next_s.quiet = 16'h0000;
          if (low != me)
          begin
            ring2[low]        = 1'b0;
            next_s.mem[low]   = 1'b0;
          end
          if (next_up(ring2, `ADDR_NONE, `ADDR_MAX) == me)
            next_s.st = ST_TURN;
        end
      ST_TURN:
        if (s.startup && !s.cfg_sent)
        begin
          next_s.tx       = {1'b1, K_LINKCFG, `ADDR_NONE, me, 8'h00, s.link_words};
          next_s.cfg_sent = 1'b1;
        end
        else if (s.link_on && s.have_word && !s.sent_dat)
        begin
          next_s.tx       = {1'b1, K_DATA, `ADDR_NONE, me, s.link_word};
          next_s.sent_dat = 1'b1;
        end
        else if (i_evt_req && !s.sent_evt && s.evt_cnt < s.p_frames)
        begin
          next_s.tx       = {1'b1, K_EVENT, `ADDR_NONE, me, i_evt_dat};
          next_s.sent_evt = 1'b1;
          next_s.evt_ack  = 1'b1;
          next_s.evt_cnt  = s.evt_cnt + 8'h01;
        end
        else
        begin
          next_s.sent_dat = 1'b0;
          next_s.sent_evt = 1'b0;
          if (nxt == me)
          begin
            next_s.st         = ST_POLL;
            next_s.round_done = 1'b1;
            next_s.polled     = 6'h00;
          end
          else
          begin
            next_s.tx = {1'b1, K_TOKEN, nxt, me, 16'h0000};
            next_s.st = ST_IDLE;
          end
        end
      ST_POLL:
        if (s.polled >= s.p_pollcnt)
        begin
          next_s.st    = ST_MEMBER;
          next_s.chunk = 2'h0;
        end
        else
        begin
          next_s.cursor = cur;
          next_s.polled = s.polled + 6'h01;
          if (cur != me)
          begin
            next_s.tx       = {1'b1, K_POLL, cur, me, 16'h0000};
            next_s.wait_cnt = 4'h0;
            next_s.st       = ST_WAIT;
          end
        end
      ST_WAIT:
        if (rx.vld && rx.kind == K_ACK && rx.src == s.cursor)
        begin
          next_s.mem[s.cursor] = 1'b1;
          next_s.st            = ST_POLL;
        end
        else if (s.wait_cnt == 4'(`POLL_WAIT_CYC))
        begin
          next_s.mem[s.cursor] = 1'b0;
          next_s.st            = ST_POLL;
        end
        else
          next_s.wait_cnt = s.wait_cnt + 4'h1;
      ST_MEMBER:
      begin
        next_s.tx    = {1'b1, K_MEMBER, 4'h0, s.chunk, me, s.mem[{s.chunk, 4'h0} +: `CHUNK_W]};
        next_s.chunk = s.chunk + 2'h1;
        if (s.chunk == `CHUNK_LAST)
        begin
          next_s.st        = ST_PARAM;
          next_s.p_cycle   = c_cycle;
          next_s.p_pollcnt = c_poll;
          next_s.p_frames  = c_frames;
          next_s.p_maxaddr = c_max;
        end
      end
      ST_PARAM:
      begin
        case (s.chunk)
          `PSEL_CYCLE:   next_s.tx = {1'b1, K_PARAM, 4'h0, s.chunk, me, 8'h00, s.p_cycle};
          `PSEL_POLLCNT: next_s.tx = {1'b1, K_PARAM, 4'h0, s.chunk, me, 10'h000, s.p_pollcnt};
          `PSEL_FRAMES:  next_s.tx = {1'b1, K_PARAM, 4'h0, s.chunk, me, 8'h00, s.p_frames};
          default:       next_s.tx = {1'b1, K_PARAM, 4'h0, s.chunk, me, 10'h000, s.p_maxaddr};
        endcase
        next_s.chunk = s.chunk + 2'h1;
        if (s.chunk == `CHUNK_LAST)
        begin
          next_s.st      = ST_TURN;
          next_s.evt_cnt = 8'h00;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase

    // Own presence and poller role
    if (!s.lamp)
      next_s.mem[me] = 1'b1;
    next_s.poller = !s.lamp && (next_up(next_s.mem, `ADDR_NONE, `ADDR_MAX) == me);

    // A node with a bad address keeps off the bus
    if (s.lamp)
    begin
      next_s.tx.vld = 1'b0;
      next_s.st     = ST_IDLE;
    end
  end

  // State register with clock enable
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      s           <= '0;
      s.p_pollcnt <= `POLLCNT_DEF;
      s.p_frames  <= `FRAMES_DEF;
      s.p_maxaddr <= `ADDR_MAX;
    end
    else if (i_ce)
      s <= next_s;
  end

  // Outputs
  assign bus.from_node      = s.tx;
  assign bus.rd_vld         = s.rd_vld;
  assign bus.rd_dat         = s.rd_dat;
  assign bus.rd_src         = s.rd_src;
  assign o_evt_ack          = s.evt_ack;
  assign o_comm_error_lamp  = s.lamp;
  assign o_poller           = s.poller;
  assign o_startup          = s.startup;
  assign o_link_on          = s.link_on;
  assign o_link_words       = s.link_words;
  assign o_members          = s.mem[62:0];
  assign o_net_cycle        = s.p_cycle;
  assign o_net_pollcnt      = s.p_pollcnt;
  assign o_net_frames       = s.p_frames;
  assign o_net_maxaddr      = s.p_maxaddr;
  assign o_round_done       = s.round_done;
  assign o_param_err        = s.param_err;
  assign o_unit_num         = s.unit_s;
  assign o_net_local        = s.net_local;
  assign o_net_err          = s.net_err;

endmodule : token_node

// file: hw/token_peer.sv
`timescale 1ns/1ns
`include "token_bus_defines.svh"
module token_peer (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  token_bus_if.peer_end    bus,
  input  wire logic [63:0] i_peers,
  input  wire logic [5:0]  i_dev_addr,
  input  wire logic        i_send_req,
  input  wire logic [15:0] i_send_dat,
  input  wire logic [15:0] i_host_word,
  output logic             o_got_vld,
  output logic [15:0]      o_got_dat,
  output logic [5:0]       o_got_src,
  output logic [15:0]      o_host_rd,
  output logic [62:0]      o_members,
  output logic [7:0]       o_net_cycle,
  output logic [5:0]       o_net_pollcnt,
  output logic [7:0]       o_net_frames,
  output logic [5:0]       o_net_maxaddr,
  output logic             o_link_on,
  output logic [7:0]       o_link_words
);
  import token_bus_pkg::*;

  peer_state_t s;
  peer_state_t next_s;

  always_comb
  begin
    logic [63:0] own;
    logic [63:0] ring;
    logic [5:0]  nxt;
    frame_t      rx;
    own             = i_peers;
    own[i_dev_addr] = 1'b0;
    ring            = own;
    ring[i_dev_addr] = 1'b1;
    rx              = bus.from_node;
    nxt             = next_up(ring, s.hold_addr, s.p_maxaddr);
    next_s          = s;
    next_s.tx       = '0;
    next_s.got_vld  = 1'b0;
    next_s.wr_vld   = 1'b0;

    // Host refresh timer
    if (s.refresh == 16'(`REFRESH_CYC - 1))
    begin
      next_s.refresh = 16'h0000;
      next_s.wr_vld  = 1'b1;
      next_s.wr_dat  = i_host_word;
    end
    else
      next_s.refresh = s.refresh + 16'h0001;
    if (bus.rd_vld)
      next_s.host_rd = bus.rd_dat;

    // Frames from the device
    if (rx.vld)
    begin
      case (rx.kind)
        K_TOKEN:
          if (own[rx.dst])
          begin
            next_s.hold_on   = 1'b1;
            next_s.hold_addr = rx.dst;
            next_s.sent      = 1'b0;
          end
        K_POLL:
          if (own[rx.dst])
            next_s.tx = {1'b1, K_ACK, rx.src, rx.dst, 16'h0000};
        K_MEMBER: next_s.mem[{rx.dst[1:0], 4'h0} +: `CHUNK_W] = rx.dat;
        K_PARAM:
          case (rx.dst[1:0])
            `PSEL_CYCLE:   next_s.p_cycle   = rx.dat[7:0];
            `PSEL_POLLCNT: next_s.p_pollcnt = rx.dat[5:0];
            `PSEL_FRAMES:  next_s.p_frames  = rx.dat[7:0];
            default:       next_s.p_maxaddr = rx.dat[5:0];
          endcase
        K_LINKCFG:
        begin
          next_s.link_on    = 1'b1;
          next_s.link_words = rx.dat[7:0];
        end
        K_DATA, K_EVENT:
        begin
          next_s.got_vld = 1'b1;
          next_s.got_dat = rx.dat;
          next_s.got_src = rx.src;
        end
        default: ;
      endcase
    end
    else if (s.hold_on)
    begin
      // Simulated peers send data only while holding the token
      if (i_send_req && !s.sent)
      begin
        next_s.tx   = {1'b1, K_DATA, `ADDR_NONE, s.hold_addr, i_send_dat};
        next_s.sent = 1'b1;
      end
      else
      begin
        next_s.tx = {1'b1, K_TOKEN, nxt, s.hold_addr, 16'h0000};
        if (own[nxt] && nxt > s.hold_addr)
        begin
          next_s.hold_addr = nxt;
          next_s.sent      = 1'b0;
        end
        else
          next_s.hold_on = 1'b0;
      end
    end
  end

  // State register with clock enable
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      s           <= '0;
      s.p_pollcnt <= `POLLCNT_DEF;
      s.p_frames  <= `FRAMES_DEF;
      s.p_maxaddr <= `ADDR_MAX;
    end
    else if (i_ce)
      s <= next_s;
  end

  // Outputs
  assign bus.from_peer   = s.tx;
  assign bus.host_wr_vld = s.wr_vld;
  assign bus.host_wr_dat = s.wr_dat;
  assign o_got_vld       = s.got_vld;
  assign o_got_dat       = s.got_dat;
  assign o_got_src       = s.got_src;
  assign o_host_rd       = s.host_rd;
  assign o_members       = s.mem[62:0];
  assign o_net_cycle     = s.p_cycle;
  assign o_net_pollcnt   = s.p_pollcnt;
  assign o_net_frames    = s.p_frames;
  assign o_net_maxaddr   = s.p_maxaddr;
  assign o_link_on       = s.link_on;
  assign o_link_words    = s.link_words;

endmodule : token_peer

// file: tb/tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
      bad_count++; \
    end \
  end
module tb_top;
  import token_bus_pkg::*;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        alloc_auto = 1'b1;
  logic        tx_seen = 1'b0;
  logic [5:0]  node_addr = 6'h01;
  logic [7:0]  net_addr = 8'h00;
  logic [15:0] rd_seen = 16'h0000;
  logic        ce = 1'b1, start_link = 1'b1, talk = 1'b1, word_seen = 1'b0;
  logic [3:0]  unit_in = 4'h9;
  logic [7:0]  cfg_cycle = 8'h20, cfg_frames = 8'h05;
  logic [5:0]  cfg_pollcnt = 6'h02, cfg_maxaddr = 6'h08, got_src;
  logic [15:0] got_dat, host_rd;
  logic [63:0] peers = 64'h0000_0000_0000_0428;
  logic        evt_ack, lamp, poller, startup, link_on, round_done, param_err, net_local, net_err, p_link_on, got_vld;
  logic [7:0]  link_words, net_cycle, net_frames, p_cycle, p_frames, p_link_words;
  logic [5:0]  net_pollcnt, net_maxaddr, p_pollcnt, p_maxaddr;
  logic [62:0] members, p_members;
  logic [3:0]  unit_num;
  logic [5:0]  bad_addr [2] = '{6'h00, 6'h3F};
  logic [7:0]  net_val [4] = '{8'h00, 8'h01, 8'h7F, 8'h80};
  logic        loc_exp [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
  logic        err_exp [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  int          bad_count = 0;
  int          total_checks = 0;
  int          rounds = 0;
  int          events = 0;

  token_bus_if bus();

  token_node #(.LOSS_CYC(40)) i_token_node (.i_clk_sys(clk_sys), .i_nrst(nrst), .i_ce(ce), .bus(bus),
    .i_node_addr(node_addr), .i_unit_num(unit_in), .i_net_addr(net_addr), .i_start_link(start_link),
    .i_alloc_auto(alloc_auto), .i_pwa_words(8'h10), .i_clp_words(8'h20), .i_cfg_cycle(cfg_cycle),
    .i_cfg_pollcnt(cfg_pollcnt), .i_cfg_frames(cfg_frames), .i_cfg_maxaddr(cfg_maxaddr), .i_evt_req(talk),
    .i_evt_dat(16'h5E11), .o_evt_ack(evt_ack), .o_comm_error_lamp(lamp), .o_poller(poller),
    .o_startup(startup), .o_link_on(link_on), .o_link_words(link_words), .o_members(members),
    .o_net_cycle(net_cycle), .o_net_pollcnt(net_pollcnt), .o_net_frames(net_frames),
    .o_net_maxaddr(net_maxaddr), .o_round_done(round_done), .o_param_err(param_err),
    .o_unit_num(unit_num), .o_net_local(net_local), .o_net_err(net_err));

  token_peer i_token_peer (.i_clk_sys(clk_sys), .i_nrst(nrst), .i_ce(ce), .bus(bus),
    .i_peers(peers), .i_dev_addr(node_addr), .i_send_req(talk),
    .i_send_dat(16'hA5C3), .i_host_word(16'h1234), .o_got_vld(got_vld), .o_got_dat(got_dat), .o_got_src(got_src),
    .o_host_rd(host_rd), .o_members(p_members), .o_net_cycle(p_cycle), .o_net_pollcnt(p_pollcnt),
    .o_net_frames(p_frames), .o_net_maxaddr(p_maxaddr), .o_link_on(p_link_on),
    .o_link_words(p_link_words));

  token_bus_asserts i_asserts (.i_clk_sys(clk_sys), .i_nrst(nrst), .from_node(bus.from_node),
    .from_peer(bus.from_peer), .host_wr_vld(bus.host_wr_vld), .host_wr_dat(bus.host_wr_dat),
    .rd_vld(bus.rd_vld), .rd_dat(bus.rd_dat), .rd_src(bus.rd_src));

  always #4 clk_sys = ~clk_sys;

  // Watch the link and the host side
  always @(posedge clk_sys)
  begin
    if (bus.rd_vld === 1'b1)
      rd_seen = bus.rd_dat;
    if (got_vld === 1'b1 && got_dat === 16'h1234 && got_src === node_addr)
      word_seen = 1'b1;
    if (bus.from_node.vld === 1'b1)
      tx_seen = 1'b1;
    if (round_done === 1'b1)
      rounds++;
    if (evt_ack === 1'b1)
      events++;
  end

  task automatic end_of_test();
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // Reset for four edges, then release
  task automatic reset_dut();
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("reset pollcnt", 6'h04, net_pollcnt)
    `CHK("reset frames", 8'h0A, net_frames)
    `CHK("reset maxaddr", 6'h3E, net_maxaddr)
    tx_seen = 1'b0;
    rounds = 0;
    events = 0;
    rd_seen = 16'h0000;
    word_seen = 1'b0;
    @(posedge clk_sys);
    nrst <= 1'b1;
  endtask : reset_dut

  // Both allocation modes, then bad node and network addresses
  initial
  begin
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clk_sys);
      alloc_auto <= m[0];
      reset_dut();
      ce <= 1'b0;
      repeat (60) @(posedge clk_sys);
      ce <= 1'b1;
      repeat (20) @(posedge clk_sys);
      #1;
      `CHK("early silent", 1'b0, tx_seen)
      `CHK("lamp", 1'b0, lamp)
      repeat (3000) @(posedge clk_sys);
      #1;
      `CHK("poller", 1'b1, poller)
      `CHK("member 3", 1'b1, members[3])
      `CHK("member 5", 1'b1, members[5])
      `CHK("member 10", 1'b0, members[10])
      `CHK("peer members", members, p_members)
      `CHK("peer cycle", 8'h20, p_cycle)
      `CHK("peer pollcnt", 6'h02, p_pollcnt)
      `CHK("peer frames", 8'h05, p_frames)
      `CHK("peer maxaddr", 6'h08, p_maxaddr)
      `CHK("param error", 1'b0, param_err)
      `CHK("startup", 1'b1, startup)
      `CHK("link on", 1'b1, link_on & p_link_on)
      `CHK("link words", m ? 8'h10 : 8'h20, link_words)
      `CHK("peer link words", m ? 8'h10 : 8'h20, p_link_words)
      `CHK("host read", 16'hA5C3, rd_seen)
      `CHK("host read back", 16'hA5C3, host_rd)
      `CHK("link word sent", 1'b1, word_seen)
      `CHK("rounds", 1'b1, rounds > 2)
      `CHK("events", 1'b1, events > 0)
      `CHK("unit number", 4'h9, unit_num)
    end
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_sys);
      node_addr <= bad_addr[k];
      cfg_frames <= 8'h04;
      start_link <= 1'b0;
      reset_dut();
      repeat (100) @(posedge clk_sys);
      #1;
      `CHK("bad addr lamp", 1'b1, lamp)
      `CHK("bad addr silent", 1'b0, tx_seen)
      `CHK("bad cfg", 1'b1, param_err)
      `CHK("no launch", 1'b0, startup)
    end
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk_sys);
      net_addr <= net_val[k];
      repeat (5) @(posedge clk_sys);
      #1;
      `CHK("net local", loc_exp[k], net_local)
      `CHK("net error", err_exp[k], net_err)
    end
    end_of_test();
  end

  // Cut a hang short
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    end_of_test();
  end
endmodule : tb_top

// file: tb/token_bus_asserts.sv
`timescale 1ns/1ns
module token_bus_asserts (
  input wire logic                  i_clk_sys,
  input wire logic                  i_nrst,
  input wire token_bus_pkg::frame_t from_node,
  input wire token_bus_pkg::frame_t from_peer,
  input wire logic                  host_wr_vld,
  input wire logic [15:0]           host_wr_dat,
  input wire logic                  rd_vld,
  input wire logic [15:0]           rd_dat,
  input wire logic [5:0]            rd_src
);
  import token_bus_pkg::*;
  logic [15:0] peer_dat;
  logic [5:0]  peer_src;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);

  // Frame of one kind carrying one selector
  function automatic logic fr(input frame_t f, input kind_t k, input logic [5:0] d);
    return f.vld && f.kind == k && f.dst == d;
  endfunction : fr

  // Last peer payload
  always_ff @(posedge i_clk_sys)
  begin
    peer_dat <= from_peer.dat;
    peer_src <= from_peer.src;
  end

  sequence s_members;
    ##[1:2] fr(from_node, K_MEMBER, 6'h01) ##[1:2] fr(from_node, K_MEMBER, 6'h02)
      ##[1:2] fr(from_node, K_MEMBER, 6'h03);
  endsequence
  sequence s_params;
    fr(from_node, K_PARAM, 6'h00) ##[1:2] fr(from_node, K_PARAM, 6'h01)
      ##[1:2] fr(from_node, K_PARAM, 6'h02) ##[1:2] fr(from_node, K_PARAM, 6'h03);
  endsequence

  property p_one_talker;
    !(from_node.vld && from_peer.vld);
  endproperty
  property p_token_up;
    from_node.vld && from_node.kind == K_TOKEN |-> from_node.dst > from_node.src;
  endproperty
  property p_src_ok;
    from_node.vld |-> from_node.src inside {[6'h01:6'h3E]};
  endproperty
  property p_poll_dst;
    from_node.vld && from_node.kind == K_POLL |-> from_node.dst inside {[6'h01:6'h3E]} && from_node.dst != from_node.src;
  endproperty
  property p_pass_on;
    from_node.vld && from_node.kind == K_TOKEN |-> ##[1:3] (from_peer.vld && from_peer.kind == K_TOKEN);
  endproperty
  property p_ring_close;
    from_peer.vld && from_peer.kind == K_TOKEN && from_peer.dst < from_peer.src
      |-> ##[1:12] (from_node.vld && from_node.kind inside {K_POLL, K_MEMBER});
  endproperty
  property p_member_order;
    fr(from_node, K_MEMBER, 6'h00) |-> s_members ##[1:2] s_params;
  endproperty
  property p_reissue;
    fr(from_node, K_PARAM, 6'h03) |-> ##[1:8] (from_node.vld && from_node.kind inside {K_TOKEN, K_POLL});
  endproperty
  property p_rd_data;
    from_peer.vld && from_peer.kind == K_DATA |=> rd_vld && rd_dat == peer_dat && rd_src == peer_src;
  endproperty

  a_one_talker: assert property (p_one_talker)
    else $error("node and peer frames overlap");
  a_token_up: assert property (p_token_up)
    else $error("token not passed upward");
  a_src_ok: assert property (p_src_ok)
    else $error("frame sent from address out of range");
  a_poll_dst: assert property (p_poll_dst)
    else $error("poll sent to bad address");
  a_pass_on: assert property (p_pass_on)
    else $error("peer kept the token");
  a_ring_close: assert property (p_ring_close)
    else $error("no control phase after token return");
  a_member_order: assert property (p_member_order)
    else $error("membership or parameter frames out of order");
  a_reissue: assert property (p_reissue)
    else $error("token not reissued after control phase");
  a_rd_data: assert property (p_rd_data)
    else $error("received word not handed to host");
endmodule : token_bus_asserts
